// ===== bench/port_wake_and_interrupt_regs_tb_top.sv
// Purpose: self-checking bench for the port wake and interrupt registers
// Assumes: classic Wishbone with ack one cycle after the request is taken
// Notes: port 1 is slot 0, port 2 is slot 1, the MAC port is slot 4
`timescale 1ns/10ps
`default_nettype none
module port_wake_and_interrupt_regs_tb_top
  import port_wake_pkg::*;
;
  localparam logic [47:0] SW_ADDR = 48'h0A1B2C3D4E5F;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [17:0] wb_adr_i = 18'h00000;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [3:0] wb_sel_i = 4'hF;
  logic wb_ack_o;
  logic [31:0] wb_dat_o;
  magic_frame_s magic_frame = '0;
  logic [NUM_PORTS-1:0] link_up_det = '0;
  logic [NUM_PORTS-1:0] energy_det = '0;
  logic [NUM_PORTS-1:0] ts_irq = '0;
  logic [NUM_PORTS-1:0] xcvr_irq = '0;
  logic [NUM_PORTS-1:0] acl_irq = '0;
  logic wake_request_pin;
  logic [NUM_PORTS-1:0] port_irq;
  logic irq;
  int n_fail = 0;
  int tests_run = 0;

  port_wake_and_interrupt_regs #(.ADR_W(18)) DUT (
    .clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .magic_frame(magic_frame),
    .link_up_det(link_up_det), .energy_det(energy_det), .ts_irq(ts_irq),
    .xcvr_irq(xcvr_irq), .acl_irq(acl_irq), .wake_request_pin(wake_request_pin),
    .port_irq(port_irq), .irq(irq)
  );

  always #10 clock = ~clock;

  task automatic summarize;
    if (n_fail == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  function automatic logic [15:0] pidx(input logic [3:0] n, input logic [11:0] o);
    return {n, o};
  endfunction : pidx

  task automatic xfer(input logic we, input logic [15:0] idx, input logic [7:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h000000, d};
    @(posedge clock);
    while (wb_ack_o !== 1'b1 && n < 20) begin
      n++;
      @(posedge clock);
    end
    if (n == 20)
      n_fail++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, idx, d, q);
  endtask : wr

  task automatic rd(input logic [15:0] idx, input logic [7:0] exp);
    logic [31:0] q;
    xfer(1'b0, idx, 8'h00, q);
    check(q, {24'h000000, exp});
  endtask : rd

  task automatic pulse(input logic [4:0] lk, input logic [4:0] en, input logic [4:0] ac);
    @(posedge clock);
    link_up_det <= lk;
    energy_det <= en;
    acl_irq <= ac;
    @(posedge clock);
    link_up_det <= '0;
    energy_det <= '0;
    acl_irq <= '0;
    tick(4);
  endtask : pulse

  task automatic magic(input logic [47:0] dst);
    @(posedge clock);
    magic_frame <= '{valid: 1'b1, port: 3'h0, dst: dst};
    @(posedge clock);
    magic_frame <= '0;
    tick(4);
  endtask : magic

  task automatic t_reset;
    rd(pidx(4'h1, OFS_WAKE_ENABLE), 8'h00);
    rd(pidx(4'h1, OFS_INT_STATUS), 8'h00);
    rd(pidx(MAC_PORT_NUM, OFS_INT_MASK), 8'h00);
    check({27'h0, port_irq}, 32'h0);
  endtask : t_reset

  task automatic t_magic;
    for (int i = 0; i < MAC_BYTES; i++)
      wr(IDX_MAC_BASE + 16'(i), SW_ADDR[47 - 8 * i -: 8]);
    wr(pidx(4'h1, OFS_WAKE_ENABLE), 8'h04);
    magic(SW_ADDR ^ 48'h1);
    check({31'h0, wake_request_pin}, 32'h0);
    rd(pidx(4'h1, OFS_WAKE_EVENT), 8'h00);
    magic(SW_ADDR);
    check({31'h0, wake_request_pin}, 32'h1);
    rd(pidx(4'h1, OFS_WAKE_EVENT), 8'h04);
    wr(pidx(4'h1, OFS_WAKE_EVENT), 8'h04);
    tick(3);
    check({31'h0, wake_request_pin}, 32'h0);
  endtask : t_magic

  task automatic t_link;
    pulse(5'h02, 5'h02, 5'h00);
    check({31'h0, wake_request_pin}, 32'h0);
    rd(pidx(4'h2, OFS_WAKE_EVENT), 8'h03);
    wr(pidx(4'h2, OFS_WAKE_ENABLE), 8'h02);
    tick(3);
    check({31'h0, wake_request_pin}, 32'h1);
    wr(pidx(4'h2, OFS_WAKE_EVENT), 8'h02);
    tick(3);
    check({31'h0, wake_request_pin}, 32'h0);
    wr(pidx(4'h2, OFS_WAKE_ENABLE), 8'h01);
    tick(3);
    check({31'h0, wake_request_pin}, 32'h1);
    wr(pidx(4'h2, OFS_WAKE_EVENT), 8'h01);
    wr(pidx(4'h2, OFS_WAKE_ENABLE), 8'h02);
    wr(pidx(4'h3, OFS_WAKE_ENABLE), 8'h01);
    pulse(5'h06, 5'h04, 5'h00);
    check({31'h0, wake_request_pin}, 32'h1);
    rd(pidx(4'h3, OFS_WAKE_EVENT), 8'h03);
    wr(pidx(4'h2, OFS_WAKE_EVENT), 8'h02);
    wr(pidx(4'h3, OFS_WAKE_EVENT), 8'h03);
    wr(pidx(MAC_PORT_NUM, OFS_WAKE_ENABLE), 8'hFF);
    rd(pidx(MAC_PORT_NUM, OFS_WAKE_ENABLE), 8'h04);
    pulse(5'h10, 5'h10, 5'h00);
    check({31'h0, wake_request_pin}, 32'h0);
    rd(pidx(MAC_PORT_NUM, OFS_WAKE_EVENT), 8'h00);
  endtask : t_link

  task automatic t_status;
    @(posedge clock);
    ts_irq <= 5'h19;
    xcvr_irq <= 5'h19;
    tick(3);
    rd(pidx(4'h1, OFS_INT_STATUS), 8'h06);
    rd(pidx(MAC_PORT_NUM, OFS_INT_STATUS), 8'h00);
    rd(pidx(4'h4, OFS_INT_STATUS), 8'h06);
    check({27'h0, port_irq}, 32'h09);
    wr(pidx(4'h1, OFS_INT_MASK), 8'hFE);
    wr(pidx(4'h4, OFS_INT_MASK), 8'hFF);
    tick(2);
    check({27'h0, port_irq}, 32'h00);
    rd(pidx(4'h1, OFS_INT_MASK), 8'h06);
    @(posedge clock);
    ts_irq <= '0;
    xcvr_irq <= '0;
    pulse(5'h00, 5'h00, 5'h10);
    rd(pidx(MAC_PORT_NUM, OFS_INT_STATUS), 8'h01);
    check({27'h0, port_irq}, 32'h10);
    wr(pidx(MAC_PORT_NUM, OFS_INT_MASK), 8'h07);
    rd(pidx(MAC_PORT_NUM, OFS_INT_MASK), 8'h01);
    rd(pidx(MAC_PORT_NUM, OFS_INT_STATUS), 8'h00);
  endtask : t_status

  task automatic t_irq;
    wr(pidx(4'h1, OFS_INT_MASK), 8'h00);
    wr(IDX_IRQ_STATUS, 8'h1F);
    wr(IDX_IRQ_MASK, 8'h01);
    rd(IDX_IRQ_STATUS, 8'h00);
    check({31'h0, irq}, 32'h0);
    pulse(5'h00, 5'h00, 5'h01);
    check({31'h0, irq}, 32'h1);
    rd(IDX_IRQ_STATUS, 8'h01);
    wr(IDX_IRQ_MASK, 8'h00);
    tick(2);
    check({31'h0, irq}, 32'h0);
    wr(IDX_IRQ_MASK, 8'h01);
    wr(pidx(4'h1, OFS_INT_MASK), 8'h01);
    rd(pidx(4'h1, OFS_INT_STATUS), 8'h00);
    wr(IDX_IRQ_STATUS, 8'h01);
    tick(2);
    check({31'h0, irq}, 32'h0);
    wr(16'h0300, 8'hFF);
    rd(16'h0300, 8'h00);
  endtask : t_irq

  initial begin
    tick(4);
    rst_n <= 1'b1;
    tick(1);
    t_reset();
    t_magic();
    t_link();
    t_status();
    t_irq();
    summarize();
  end

  initial begin
    #400000;
    n_fail++;
    summarize();
  end
endmodule : port_wake_and_interrupt_regs_tb_top
`default_nettype wire

// ===== hw/port_wake_and_interrupt_regs.sv
// Purpose: per-port wake source and port interrupt registers on classic Wishbone
// Assumes: detector inputs synchronous to clock; pulses last one cycle
// Notes: wake pin and interrupt outputs are active high and registered
`timescale 1ns/10ps
`default_nettype none
module port_wake_and_interrupt_regs
  import port_wake_pkg::*;
#(
  parameter int ADR_W = 18
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire magic_frame_s magic_frame,
  input wire logic [NUM_PORTS-1:0] link_up_det,
  input wire logic [NUM_PORTS-1:0] energy_det,
  input wire logic [NUM_PORTS-1:0] ts_irq,
  input wire logic [NUM_PORTS-1:0] xcvr_irq,
  input wire logic [NUM_PORTS-1:0] acl_irq,
  output logic wake_request_pin,
  output logic [NUM_PORTS-1:0] port_irq,
  output logic irq
);

  function automatic logic [2:0] port_slot(input logic [3:0] n);
    if (n >= 4'h1 && n <= 4'h4) begin
      return 3'(n - 4'h1);
    end else if (n == MAC_PORT_NUM) begin
      return MAC_SLOT;
    end else begin
      return NO_SLOT;
    end
  endfunction : port_slot

  function automatic logic [2:0] avail(input int p, input logic [2:0] phy,
                                       input logic [2:0] mac);
    return (p == int'(MAC_SLOT)) ? mac : phy;
  endfunction : avail

  logic [NUM_PORTS-1:0][2:0] evt_reg;
  logic [NUM_PORTS-1:0][2:0] wen_reg;
  logic [NUM_PORTS-1:0][2:0] sts_reg;
  logic [NUM_PORTS-1:0][2:0] msk_reg;
  logic [MAC_BYTES-1:0][7:0] mac_reg;
  logic [4:0] ists_reg;
  logic [4:0] imsk_reg;
  logic [47:0] mac_addr;
  logic [15:0] idx;
  logic [11:0] low;
  logic [2:0] slot;
  logic acc;
  logic wr;
  logic [7:0] wd;
  logic [NUM_PORTS-1:0] wr_evt;
  logic [NUM_PORTS-1:0] wr_wen;
  logic [NUM_PORTS-1:0] wr_msk;
  logic [NUM_PORTS-1:0] acl_clr;
  logic [NUM_PORTS-1:0] magic_hit;
  logic [NUM_PORTS-1:0] preq;
  logic [MAC_BYTES-1:0] wr_mac;
  logic wr_ists;
  logic wr_imsk;
  logic wake_next;
  logic [7:0] rd_next;

  // Byte 0 is the first byte on the wire
  always_comb begin
    for (int k = 0; k < MAC_BYTES; k++) begin
      mac_addr[47-8*k -: 8] = mac_reg[k];
    end
  end

  // Bus decode
  always_comb begin
    idx = wb_adr_i[17:2];
    low = idx[11:0];
    slot = port_slot(idx[15:12]);
    acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wr = acc && wb_we_i && wb_sel_i[0];
    wd = wb_dat_i[7:0];
    for (int p = 0; p < NUM_PORTS; p++) begin
      wr_evt[p] = wr && slot == 3'(p) && low == OFS_WAKE_EVENT;
      wr_wen[p] = wr && slot == 3'(p) && low == OFS_WAKE_ENABLE;
      wr_msk[p] = wr && slot == 3'(p) && low == OFS_INT_MASK;
      acl_clr[p] = wr_msk[p] && (wd[BIT_ACL] != msk_reg[p][BIT_ACL]);
    end
    for (int k = 0; k < MAC_BYTES; k++) begin
      wr_mac[k] = wr && idx == IDX_MAC_BASE + 16'(k);
    end
    wr_ists = wr && idx == IDX_IRQ_STATUS;
    wr_imsk = wr && idx == IDX_IRQ_MASK;
  end

  // Magic packet qualification against the switch address
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      magic_hit[p] = magic_frame.valid && magic_frame.port == 3'(p)
                     && magic_frame.dst == mac_addr;
    end
  end

  // Wake event flags; a new event wins over the clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      evt_reg <= {NUM_PORTS{RST_PORT_REG}};
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        evt_reg[p] <= ((evt_reg[p] & ~(wr_evt[p] ? wd[2:0] : 3'h0))
                      | {magic_hit[p], link_up_det[p], energy_det[p]})
                      & avail(p, WAKE_BITS_PHY, WAKE_BITS_MAC);
      end
    end
  end

  // Wake source enables
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wen_reg <= {NUM_PORTS{RST_PORT_REG}};
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (wr_wen[p]) begin
          wen_reg[p] <= wd[2:0] & avail(p, WAKE_BITS_PHY, WAKE_BITS_MAC);
        end
      end
    end
  end

  // Wake pin from enabled events only
  always_comb begin
    wake_next = 1'b0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      wake_next = wake_next | (|(evt_reg[p] & wen_reg[p]));
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wake_request_pin <= 1'b0;
    end else begin
      wake_request_pin <= wake_next;
    end
  end

  // Port status: summaries of port-local sources only
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sts_reg <= {NUM_PORTS{RST_PORT_REG}};
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        sts_reg[p][BIT_TS] <= ts_irq[p] && p != int'(MAC_SLOT);
        sts_reg[p][BIT_XCVR] <= xcvr_irq[p] && p != int'(MAC_SLOT);
        sts_reg[p][BIT_ACL] <= (sts_reg[p][BIT_ACL] && !acl_clr[p])
                               || acl_irq[p];
      end
    end
  end

  // Port masks, one disables
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      msk_reg <= {NUM_PORTS{RST_PORT_REG}};
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (wr_msk[p]) begin
          msk_reg[p] <= wd[2:0] & avail(p, INT_BITS_PHY, INT_BITS_MAC);
        end
      end
    end
  end

  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      preq[p] = |(sts_reg[p] & ~msk_reg[p]);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      port_irq <= '0;
    end else begin
      port_irq <= preq;
    end
  end

  // Block interrupt: rising port request is sticky, write one clears
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ists_reg <= RST_IRQ_REG;
    end else begin
      ists_reg <= (ists_reg & ~(wr_ists ? wd[4:0] : 5'h00)) | (preq & ~port_irq);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      imsk_reg <= RST_IRQ_REG;
    end else if (wr_imsk) begin
      imsk_reg <= wd[4:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ists_reg & imsk_reg);
    end
  end

  // Switch address bytes
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mac_reg <= {MAC_BYTES{RST_MAC_BYTE}};
    end else begin
      for (int k = 0; k < MAC_BYTES; k++) begin
        if (wr_mac[k]) begin
          mac_reg[k] <= wd;
        end
      end
    end
  end

  // Read mux; unmapped reads return zero
  always_comb begin
    rd_next = 8'h00;
    if (slot != NO_SLOT) begin
      if (low == OFS_WAKE_EVENT) begin
        rd_next = {5'h00, evt_reg[slot]};
      end else if (low == OFS_WAKE_ENABLE) begin
        rd_next = {5'h00, wen_reg[slot]};
      end else if (low == OFS_INT_STATUS) begin
        rd_next = {5'h00, sts_reg[slot]};
      end else if (low == OFS_INT_MASK) begin
        rd_next = {5'h00, msk_reg[slot]};
      end
    end else if (idx == IDX_IRQ_STATUS) begin
      rd_next = {3'h0, ists_reg};
    end else if (idx == IDX_IRQ_MASK) begin
      rd_next = {3'h0, imsk_reg};
    end else if (idx >= IDX_MAC_BASE && idx < IDX_MAC_BASE + 16'(MAC_BYTES)) begin
      rd_next = mac_reg[3'(idx - IDX_MAC_BASE)];
    end
  end

  // Ack one cycle after the request, dropped the next cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= RST_WB_DATA;
    end else begin
      wb_ack_o <= acc;
      if (acc && !wb_we_i) begin
        wb_dat_o <= {24'h000000, rd_next};
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Bus handshake
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked next cycle");
  a_rd_reserved: assert property (
    acc && !wb_we_i && slot != NO_SLOT |=> wb_dat_o[31:3] == 29'h0)
    else $error("reserved bits read nonzero");

  // Wake path
  a_magic_wake: assert property (
    magic_hit[0] && wen_reg[0][BIT_MAGIC] && !wr_wen[0] |-> ##2 wake_request_pin)
    else $error("magic packet did not raise wake");
  a_magic_reject: assert property (
    magic_frame.valid && magic_frame.dst != mac_addr && !evt_reg[0][BIT_MAGIC]
    && magic_frame.port == 3'h0 |=> !evt_reg[0][BIT_MAGIC])
    else $error("foreign address flagged as magic packet");
  a_link_wake: assert property (
    link_up_det[1] && wen_reg[1][BIT_LINK] && !wr_wen[1] |-> ##2 wake_request_pin)
    else $error("link up did not raise wake");
  a_energy_wake: assert property (
    energy_det[2] && wen_reg[2][BIT_ENERGY] && !wr_wen[2] |-> ##2 wake_request_pin)
    else $error("energy did not raise wake");
  a_wake_blocked: assert property (
    wen_reg == '0 && !(|wr_wen) |=> ##1 !wake_request_pin)
    else $error("wake raised with all enables clear");
  a_pin_idle: assert property (
    (evt_reg & wen_reg) == '0 |=> !wake_request_pin)
    else $error("wake raised without an enabled event");
  a_evt_clear: assert property (
    wr_evt[1] && wd[BIT_LINK] && !link_up_det[1] |=> !evt_reg[1][BIT_LINK])
    else $error("wake event flag not cleared by write");
  a_mac_no_phy: assert property (
    evt_reg[MAC_SLOT][1:0] == 2'h0 && wen_reg[MAC_SLOT][1:0] == 2'h0
    && sts_reg[MAC_SLOT][2:1] == 2'h0)
    else $error("transceiver bits active on MAC port");

  // Port status and masks
  a_ts_follow: assert property (
    ts_irq[0] |=> sts_reg[0][BIT_TS])
    else $error("timestamp summary not recorded");
  a_xcvr_follow: assert property (
    xcvr_irq[3] |=> sts_reg[3][BIT_XCVR])
    else $error("transceiver summary not recorded");
  a_status_drop: assert property (
    !ts_irq[0] && !xcvr_irq[0] |=> sts_reg[0][2:1] == 2'h0)
    else $error("status bits set without a source");
  a_acl_set: assert property (
    acl_irq[MAC_SLOT] |=> sts_reg[MAC_SLOT][BIT_ACL])
    else $error("ACL interrupt not recorded");
  a_acl_sticky: assert property (
    sts_reg[MAC_SLOT][BIT_ACL] && !acl_clr[MAC_SLOT] |=> sts_reg[MAC_SLOT][BIT_ACL])
    else $error("ACL status lost without a toggle");
  a_acl_toggle: assert property (
    sts_reg[0][BIT_ACL] && acl_clr[0] && !acl_irq[0] |=> !sts_reg[0][BIT_ACL] ##1
    (!port_irq[0] || ($past(sts_reg[0][2:1]) & ~$past(msk_reg[0][2:1])) != 2'h0))
    else $error("ACL status not cleared by mask toggle");
  a_mac_acl_clear: assert property (
    sts_reg[MAC_SLOT][BIT_ACL] && acl_clr[MAC_SLOT] && !acl_irq[MAC_SLOT]
    |=> !sts_reg[MAC_SLOT][BIT_ACL])
    else $error("MAC port ACL status not cleared by toggle");
  a_mac_mask: assert property (
    wr_msk[MAC_SLOT] |=> msk_reg[MAC_SLOT] == {2'h0, $past(wd[BIT_ACL])})
    else $error("MAC port mask holds transceiver bits");
  a_mask_gate: assert property (
    sts_reg[3] != 3'h0 && msk_reg[3] == 3'h0 |=> port_irq[3])
    else $error("unmasked status did not request");
  a_mask_block: assert property (
    msk_reg[3] == 3'h7 |=> !port_irq[3])
    else $error("masked status raised request");

  // Block interrupt
  a_ists_set: assert property (
    preq[0] && !port_irq[0] |=> ists_reg[0])
    else $error("rising port request not recorded");
  a_ists_clear: assert property (
    wr_ists && wd[4] && !(preq[4] && !port_irq[4]) |=> !ists_reg[4])
    else $error("interrupt status not cleared by write");
  a_irq_raise: assert property (
    (ists_reg & imsk_reg) != 5'h00 |=> irq)
    else $error("unmasked status did not interrupt");
  a_irq_quiet: assert property (
    (ists_reg & imsk_reg) == 5'h00 |=> !irq)
    else $error("interrupt without unmasked status");

  c_magic_wake: cover property (magic_hit[0] ##2 wake_request_pin);
  c_link_wake: cover property (link_up_det[1] && wen_reg[1][BIT_LINK] ##2 wake_request_pin);
  c_acl_clear: cover property (sts_reg[0][BIT_ACL] ##1 acl_clr[0] ##1 !sts_reg[0][BIT_ACL]);
  c_irq_raise: cover property (!irq ##1 irq);
  c_read_back: cover property (acc && !wb_we_i && rd_next != 8'h00);

endmodule : port_wake_and_interrupt_regs
`default_nettype wire

// ===== hw/port_wake_pkg.sv
// Purpose: constants and carrier types for the port wake and interrupt registers
// Assumes: word-indexed registers, byte address is four times the index
// Notes: port slots 0-3 are transceiver ports, slot 4 is the external MAC port
package port_wake_pkg;
  localparam int NUM_PORTS = 5;
  localparam logic [2:0] MAC_SLOT = 3'h4;
  localparam logic [2:0] NO_SLOT = 3'h7;
  localparam logic [3:0] MAC_PORT_NUM = 4'h7;
  // Register indices within a port page
  localparam logic [11:0] OFS_WAKE_EVENT = 12'h013;
  localparam logic [11:0] OFS_WAKE_ENABLE = 12'h017;
  localparam logic [11:0] OFS_INT_STATUS = 12'h01B;
  localparam logic [11:0] OFS_INT_MASK = 12'h01F;
  // Block-level registers in page 0
  localparam logic [15:0] IDX_IRQ_STATUS = 16'h0100;
  localparam logic [15:0] IDX_IRQ_MASK = 16'h0101;
  localparam logic [15:0] IDX_MAC_BASE = 16'h0200;
  localparam int MAC_BYTES = 6;
  // Field positions
  localparam int BIT_MAGIC = 2;
  localparam int BIT_LINK = 1;
  localparam int BIT_ENERGY = 0;
  localparam int BIT_TS = 2;
  localparam int BIT_XCVR = 1;
  localparam int BIT_ACL = 0;
  // Implemented bits per port kind
  localparam logic [2:0] WAKE_BITS_PHY = 3'h7;
  localparam logic [2:0] WAKE_BITS_MAC = 3'h4;
  localparam logic [2:0] INT_BITS_PHY = 3'h7;
  localparam logic [2:0] INT_BITS_MAC = 3'h1;
  // Reset values
  localparam logic [2:0] RST_PORT_REG = 3'h0;
  localparam logic [4:0] RST_IRQ_REG = 5'h00;
  localparam logic [7:0] RST_MAC_BYTE = 8'h00;
  localparam logic [31:0] RST_WB_DATA = 32'h0000_0000;

  typedef struct packed {
    logic valid;
    logic [2:0] port;
    logic [47:0] dst;
  } magic_frame_s;
endpackage : port_wake_pkg
